//--- core/ecl_pkg.sv
// Constants and types of the configuration image loader.
// Assumes a byte-wide reader of the serial image store and an APB master outside.
package ecl_pkg;
	// Image layout, byte offsets
	localparam logic [6:0] IMG_VER_MAJOR = 7'h02;
	localparam logic [6:0] IMG_VER_MINOR = 7'h03;
	localparam logic [6:0] IMG_STA_ADDR = 7'h08;
	localparam logic [6:0] IMG_BOOT_EN = 7'h14;
	localparam logic [6:0] IMG_BOOT_SEL = 7'h15;
	localparam logic [6:0] IMG_SUBSYS_ID = 7'h24;
	localparam logic [6:0] IMG_SUBSYS_VID = 7'h26;
	localparam logic [6:0] IMG_CIS_PTR = 7'h2A;
	localparam logic [6:0] IMG_CCC_HI = 7'h2E;
	localparam logic [6:0] IMG_CRC_LAST = 7'h7D;
	localparam logic [6:0] IMG_CSUM = 7'h7E;
	localparam logic [6:0] IMG_LAST = 7'h7F;
	// Expected layout version
	localparam logic [7:0] VER_MAJOR_EXP = 8'h02;
	localparam logic [7:0] VER_MINOR_EXP = 8'h00;
	// Boot method codes
	localparam logic [7:0] BOOT_INT18 = 8'h00;
	localparam logic [7:0] BOOT_INT19 = 8'h01;
	localparam logic [7:0] BOOT_BEV = 8'h02;
	localparam logic [7:0] BOOT_RPL = 8'h10;
	// Frame check sequence, reflected form
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	// Register byte offsets on APB
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_STA_LO = 8'h08;
	localparam logic [7:0] REG_STA_HI = 8'h0C;
	localparam logic [7:0] REG_BOOT = 8'h10;
	localparam logic [7:0] REG_SUBSYS = 8'h14;
	localparam logic [7:0] REG_CIS = 8'h18;
	localparam logic [7:0] REG_CCC = 8'h1C;
	// Field positions
	localparam int CTRL_RELOAD_BIT = 0;
	localparam int CCC_WOL_BIT = 18;
	localparam int CCC_HI_LSB = 16;
	// Reset values
	localparam logic [31:0] CCC_RESET = 32'h00000000;
	localparam logic [31:0] CIS_RESET = 32'h00000000;

	typedef enum logic [1:0] {ST_REQ, ST_WAIT, ST_CHECK, ST_DONE} ecl_phase_e;

	// Values recalled from the image
	typedef struct packed {
		logic [47:0] sta_addr;
		logic [7:0] boot_en;
		logic [7:0] boot_sel;
		logic [15:0] subsys_id;
		logic [15:0] subsys_vid;
		logic [31:0] cis_ptr;
		logic [31:0] ccc;
	} ecl_cfg_s;

	// One byte step of the frame check sequence
	function automatic logic [31:0] ecl_crc_byte(input logic [31:0] crc, input logic [7:0] data);
		logic [31:0] c;
		c = crc ^ {24'h000000, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
endpackage

//--- core/ecl_loader.sv
// Configuration image loader: reads the 128-byte image after reset, fills the
// configuration values and serves them over APB.
// Assumes a byte reader that answers ee_rd_req with a one-cycle ee_rd_valid.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps

module ecl_loader
	import ecl_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic ee_rd_req,
	output logic [6:0] ee_rd_addr,
	input wire logic ee_rd_valid,
	input wire logic [7:0] ee_rd_data,
	output ecl_cfg_s cfg,
	output logic wol_en,
	output logic load_done
);

	typedef struct packed {
		ecl_phase_e st;
		logic [6:0] addr;
		logic req;
		logic [31:0] crc;
		logic [15:0] csum_img;
		logic [7:0] ver_major;
		logic [7:0] ver_minor;
		logic csum_ok;
		logic done;
		ecl_cfg_s cfg;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ecl_state_s;

	localparam ecl_state_s STATE_RESET = '{
		st: ST_REQ,
		addr: 7'h00,
		req: 1'b0,
		crc: CRC_INIT,
		csum_img: 16'h0000,
		ver_major: 8'h00,
		ver_minor: 8'h00,
		csum_ok: 1'b0,
		done: 1'b0,
		cfg: '{sta_addr: 48'h000000000000, boot_en: 8'h00, boot_sel: 8'h00,
			subsys_id: 16'h0000, subsys_vid: 16'h0000, cis_ptr: CIS_RESET, ccc: CCC_RESET},
		prdata: 32'h00000000,
		pready: 1'b0,
		pslverr: 1'b0
	};

	ecl_state_s state_reg;
	ecl_state_s state_next;
	logic ver_ok;
	logic boot_known;
	logic [6:0] rel;
	logic [7:0] b;

	// Status terms decoded from the recalled bytes
	always_comb begin
		ver_ok = (state_reg.ver_major == VER_MAJOR_EXP) && (state_reg.ver_minor == VER_MINOR_EXP);
		case (state_reg.cfg.boot_sel)
			BOOT_INT18, BOOT_INT19, BOOT_BEV, BOOT_RPL: boot_known = 1'b1;
			default: boot_known = 1'b0;
		endcase
	end

	// Loader sequence and register bus in one next-state process
	always_comb begin
		state_next = state_reg;
		b = ee_rd_data;
		rel = 7'h00;
		case (state_reg.st)
			ST_REQ: begin
				state_next.req = 1'b1;
				state_next.st = ST_WAIT;
			end
			ST_WAIT: begin
				if (ee_rd_valid) begin
					state_next.req = 1'b0;
					// Checksum covers everything below its own two bytes
					if (state_reg.addr <= IMG_CRC_LAST) begin
						state_next.crc = ecl_crc_byte(state_reg.crc, b);
					end
					if (state_reg.addr == IMG_VER_MAJOR) begin
						state_next.ver_major = b;
					end
					if (state_reg.addr == IMG_VER_MINOR) begin
						state_next.ver_minor = b;
					end
					if (state_reg.addr >= IMG_STA_ADDR && state_reg.addr < IMG_STA_ADDR + 7'd6) begin
						rel = state_reg.addr - IMG_STA_ADDR;
						state_next.cfg.sta_addr[8 * rel[2:0] +: 8] = b;
					end
					if (state_reg.addr == IMG_BOOT_EN) begin
						state_next.cfg.boot_en = b;
					end
					if (state_reg.addr == IMG_BOOT_SEL) begin
						state_next.cfg.boot_sel = b;
					end
					// Two-byte fields are stored low byte first
					if (state_reg.addr[6:1] == IMG_SUBSYS_ID[6:1]) begin
						state_next.cfg.subsys_id[8 * state_reg.addr[0] +: 8] = b;
					end
					if (state_reg.addr[6:1] == IMG_SUBSYS_VID[6:1]) begin
						state_next.cfg.subsys_vid[8 * state_reg.addr[0] +: 8] = b;
					end
					if (state_reg.addr >= IMG_CIS_PTR && state_reg.addr < IMG_CIS_PTR + 7'd4) begin
						rel = state_reg.addr - IMG_CIS_PTR;
						state_next.cfg.cis_ptr[8 * rel[1:0] +: 8] = b;
					end
					// Upper half of control, wake enable included
					if (state_reg.addr[6:1] == IMG_CCC_HI[6:1]) begin
						state_next.cfg.ccc[CCC_HI_LSB + 8 * state_reg.addr[0] +: 8] = b;
					end
					if (state_reg.addr[6:1] == IMG_CSUM[6:1]) begin
						state_next.csum_img[8 * state_reg.addr[0] +: 8] = b;
					end
					if (state_reg.addr == IMG_LAST) begin
						state_next.st = ST_CHECK;
					end else begin
						state_next.addr = state_reg.addr + 7'd1;
						state_next.st = ST_REQ;
					end
				end
			end
			ST_CHECK: begin
				// Least significant two bytes of the complemented remainder
				state_next.csum_ok = (~state_reg.crc[15:0]) == state_reg.csum_img;
				state_next.done = 1'b1;
				state_next.st = ST_DONE;
			end
			ST_DONE: begin
				state_next.st = ST_DONE;
			end
			default: begin
				state_next.st = ST_REQ;
			end
		endcase

		// APB: answer held back until the image is fully loaded
		if (psel && penable && !state_reg.pready && state_reg.done) begin
			state_next.pready = 1'b1;
			state_next.pslverr = 1'b0;
			state_next.prdata = 32'h00000000;
			case (paddr)
				REG_CTRL: state_next.prdata = 32'h00000000;
				REG_STATUS: state_next.prdata = {8'h00, state_reg.ver_minor, state_reg.ver_major,
					4'h0, boot_known, state_reg.csum_ok, ver_ok, state_reg.done};
				REG_STA_LO: state_next.prdata = state_reg.cfg.sta_addr[31:0];
				REG_STA_HI: state_next.prdata = {16'h0000, state_reg.cfg.sta_addr[47:32]};
				REG_BOOT: state_next.prdata = {16'h0000, state_reg.cfg.boot_sel, state_reg.cfg.boot_en};
				REG_SUBSYS: state_next.prdata = {state_reg.cfg.subsys_vid, state_reg.cfg.subsys_id};
				REG_CIS: state_next.prdata = state_reg.cfg.cis_ptr;
				REG_CCC: state_next.prdata = state_reg.cfg.ccc;
				default: state_next.pslverr = 1'b1;
			endcase
		end else if (psel && penable && state_reg.pready) begin
			// Completing edge: writes land here and nowhere else
			state_next.pready = 1'b0;
			state_next.pslverr = 1'b0;
			if (pwrite && !state_reg.pslverr) begin
				case (paddr)
					REG_CCC: state_next.cfg.ccc = pwdata;
					REG_CIS: state_next.cfg.cis_ptr = pwdata;
					REG_CTRL: begin
						// Software reset: restart the image read from byte 0
						if (pwdata[CTRL_RELOAD_BIT]) begin
							state_next = STATE_RESET;
						end
					end
					default: state_next.pslverr = 1'b0;
				endcase
			end
		end
	end

	// Single state register, synchronous reset restarts the load
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs taken straight from the state register
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign ee_rd_req = state_reg.req;
	assign ee_rd_addr = state_reg.addr;
	assign cfg = state_reg.cfg;
	assign wol_en = state_reg.cfg.ccc[CCC_WOL_BIT];
	assign load_done = state_reg.done;

endmodule // ecl_loader

//--- sim/ecl_asserts.sv
// Port-level checks of the image loader.
// Bound to every ecl_loader; sees only its ports.
`timescale 1ns/1ps
module ecl_asserts
	import ecl_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ee_rd_req,
	input wire logic [6:0] ee_rd_addr,
	input wire logic ee_rd_valid,
	input wire ecl_cfg_s cfg,
	input wire logic wol_en,
	input wire logic load_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Byte handed over by the reader
	sequence byte_taken;
		ee_rd_req && ee_rd_valid;
	endsequence
	// Idle gap, then the following address
	sequence gap_next;
		!ee_rd_req ##1 (ee_rd_req && ee_rd_addr == $past(ee_rd_addr, 2) + 7'h01);
	endsequence
	AST_START: assert property ($fell(sys_rst) |=> ee_rd_req && ee_rd_addr == 7'h00 && !load_done)
		else $error("load not started at byte 0");
	AST_HOLD: assert property (ee_rd_req && !ee_rd_valid |=> ee_rd_req && $stable(ee_rd_addr))
		else $error("request dropped early");
	AST_STEP: assert property (byte_taken ##0 ee_rd_addr != IMG_LAST |=> gap_next)
		else $error("image not read in order");
	AST_DONE: assert property (byte_taken ##0 ee_rd_addr == IMG_LAST |=> !load_done ##1 load_done)
		else $error("done flag late");
	AST_NO_EARLY: assert property (pready |-> load_done)
		else $error("bus answered before load");
	AST_WAIT: assert property (psel && penable && !$past(penable) && load_done |=> pready ##1 !pready)
		else $error("bus wait state wrong");
	AST_ERR: assert property (pslverr |-> pready && prdata == 32'h00000000)
		else $error("error reply malformed");
	AST_WOL: assert property (wol_en == cfg.ccc[CCC_WOL_BIT])
		else $error("wake enable not bit 18");
endmodule // ecl_asserts
bind ecl_loader ecl_asserts u_chk (.*);

//--- sim/ecl_eeprom_model.sv
// Serial image store seen as a byte reader.
// lat sets answer delay; bench loads mem directly.
`timescale 1ns/1ps
module ecl_eeprom_model (
	input wire logic clk,
	input wire logic ee_rd_req,
	input wire logic [6:0] ee_rd_addr,
	input wire logic [3:0] lat,
	output logic ee_rd_valid,
	output logic [7:0] ee_rd_data
);
	logic [7:0] mem [128];
	logic [3:0] cnt = 4'h0;
	initial ee_rd_valid = 1'b0;
	initial ee_rd_data = 8'h00;
	// Answer after lat idle cycles, one-cycle pulse
	always @(posedge clk) begin
		ee_rd_valid <= 1'b0;
		ee_rd_data <= ~ee_rd_data; // No stale byte once released
		if (ee_rd_req && !ee_rd_valid) begin
			cnt <= (cnt >= lat) ? 4'h0 : cnt + 4'h1;
			if (cnt >= lat) begin
				ee_rd_valid <= 1'b1;
				ee_rd_data <= mem[ee_rd_addr];
			end
		end
	end
endmodule // ecl_eeprom_model

//--- sim/ecl_loader_tb.sv
// Self-checking bench of the image loader.
// Drives APB and the reader model; checker binds itself.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module ecl_loader_tb;
	import ecl_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
	logic ee_rd_req, ee_rd_valid, wol_en, load_done;
	logic [7:0] paddr = 8'h00, ee_rd_data;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic [6:0] ee_rd_addr;
	logic [3:0] lat = 4'h0;
	logic [7:0] m [128];
	logic [7:0] sels [6] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h03, 8'h02};
	ecl_cfg_s cfg;
	int errors = 0, n_checks = 0;
	ecl_loader dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ee_rd_req(ee_rd_req),
		.ee_rd_addr(ee_rd_addr), .ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data), .cfg(cfg), .wol_en(wol_en),
		.load_done(load_done));
	ecl_eeprom_model ee (.clk(clk), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr), .lat(lat),
		.ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data));
	initial begin
		forever #5 clk = ~clk;
	end
	// Counts, verdict, end of run
	task complete_run;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// One APB transfer; pready, prdata and pslverr taken at the rising edge that completes it
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		bit seen;
		seen = 1'b0;
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		for (int i = 0; i < 3000 && !seen; i++) begin
			@(posedge clk);
			if (pready === 1'b1) begin
				seen = 1'b1;
				rd = prdata;
				er = pslverr;
			end
		end
		if (!seen) begin
			errors++;
			complete_run();
		end
		{psel, penable} <= 2'b00;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		`CHK($sformatf("reg %h", a), e, rd)
	endtask
	// Image with boot code and major version; bad spoils the checksum
	task make_image(input logic [7:0] sel, input logic [7:0] maj, input logic bad);
		logic [31:0] c;
		for (int i = 0; i < 128; i++) ee.mem[i] = 8'(i * 7 + 1);
		{ee.mem[2], ee.mem[3], ee.mem[21]} = {maj, 8'h00, sel};
		c = 32'hFFFFFFFF;
		for (int i = 0; i < 126; i++) begin
			c ^= {24'h000000, ee.mem[i]};
			for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
		end
		{ee.mem[127], ee.mem[126]} = ~c[15:0] ^ {15'h0000, bad};
		m = ee.mem;
	endtask
	// Reload, status read waits out the load, then every field
	task check_load(input logic [7:0] sel, input logic [7:0] maj, input logic bad);
		make_image(sel, maj, bad);
		apb(1'b1, REG_CTRL, 32'h00000001);
		rdchk(REG_STATUS, {16'h0000, maj, 4'h0, sel inside {8'h00, 8'h01, 8'h02, 8'h10}, !bad, maj == 8'h02, 1'b1});
		rdchk(REG_STA_LO, {m[11], m[10], m[9], m[8]});
		rdchk(REG_STA_HI, {16'h0000, m[13], m[12]});
		rdchk(REG_BOOT, {16'h0000, sel, m[20]});
		rdchk(REG_SUBSYS, {m[39], m[38], m[37], m[36]});
		rdchk(REG_CIS, {m[45], m[44], m[43], m[42]});
		rdchk(REG_CCC, {m[47], m[46], 16'h0000});
		`CHK("wol_en", m[46][2], wol_en)
	endtask
	// Driver overrides wake bit; a hole reads as zero with an error
	task check_writes;
		apb(1'b1, REG_CCC, 32'h00040000);
		@(negedge clk);
		`CHK("wol_en", 1'b1, wol_en)
		apb(1'b1, 8'h40, 32'hFFFFFFFF);
		rdchk(8'h40, 32'h00000000);
		`CHK("pslverr", 1'b1, er)
		rdchk(REG_CIS, {m[45], m[44], m[43], m[42]});
	endtask
	initial begin
		make_image(8'h00, 8'h02, 1'b0);
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		for (int k = 0; k < 6; k++) begin
			lat <= 4'(k);
			check_load(sels[k], k == 5 ? 8'h03 : 8'h02, k == 4);
		end
		check_writes();
		complete_run();
	end
endmodule // ecl_loader_tb
